//--- core/ulpt_link_power_cfg.sv
module ulpt_link_power_cfg
    import ulpt_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int HS_BASE_BITS = ULPT_HS_BASE_DEFAULT
)
(
    input wire logic clk,
    input wire logic nrst,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Resets and configuration image
    input wire logic usb_bus_reset,
    input wire logic lite_soft_reset,
    input wire logic reset_protect,
    input wire logic eeprom_present,
    input wire logic [7:0] eeprom_u1_wait,
    input wire logic [1:0] eeprom_u2_bits,
    input wire logic otp_programmed,
    input wire logic [7:0] otp_u1_wait,
    input wire logic [1:0] otp_u2_bits,
    // Link state
    input wire logic host_u1_feature,
    input wire logic host_u2_feature,
    input wire logic link_idle,
    input wire logic lmp_u2_valid,
    input wire logic [7:0] lmp_u2_value,
    output logic u1_entry_request,
    output logic u2_initiate_permit,
    output logic u2_accept_permit,
    // High-speed inter-packet wait
    input wire logic hs_bit_tick,
    input wire logic hs_wait_start,
    input wire logic hs_wait_stop,
    output logic [9:0] hs_timeout_bits,
    output logic hs_wait_expired
);

    initial
    begin
        if (HS_BASE_BITS < ULPT_HS_TIMEOUT_MIN ||
            HS_BASE_BITS > ULPT_HS_TIMEOUT_MAX)
        begin
            $error("HS_BASE_BITS outside the high-speed window");
        end
        if (ADDR_W < 12 || ADDR_W > 32)
        begin
            $error("ADDR_W must be 12 to 32");
        end
    end

    localparam logic [7:0] US_PRESCALE_LAST = 8'(ULPT_CYCLES_PER_US - 1);

    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
        reg_hit = (addr[11:2] == ULPT_CFG_OFFSET[11:2]) &&
                  ((ADDR_W == 12) || (addr >> 12) == '0);
    endfunction

    function automatic logic [7:0] byte_merge(input logic [7:0] old_v,
                                              input logic [7:0] new_v,
                                              input logic en);
        byte_merge = en ? new_v : old_v;
    endfunction

    // Configuration fields
    logic [7:0] u1_idle_wait_us_q;
    logic [7:0] u2_inactivity_limit_q;
    logic [2:0] hs_phy_delay_trim_q;
    logic u2_entry_initiation_allow_q;
    logic u2_host_request_accept_q;
    logic image_load_q;

    // Bus state
    logic aw_held_q;
    logic w_held_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;

    logic link_reset;
    logic reload;
    logic wr_fire;
    logic wr_hit;
    logic [7:0] image_u1;
    logic [1:0] image_u2;
    logic [31:0] cfg_word;

    assign link_reset = usb_bus_reset | lite_soft_reset;
    assign reload = image_load_q | link_reset;
    assign wr_fire = aw_held_q & w_held_q & ~bvalid_q;
    assign wr_hit = wr_fire & reg_hit(awaddr_q);

    // EEPROM first, then OTP, else the built-in value
    always_comb
    begin
        image_u1 = ULPT_U1_RESET;
        image_u2 = {ULPT_U2_INIT_RESET, ULPT_U2_ACC_RESET};
        if (eeprom_present)
        begin
            image_u1 = eeprom_u1_wait;
            image_u2 = eeprom_u2_bits;
        end
        else if (otp_programmed)
        begin
            image_u1 = otp_u1_wait;
            image_u2 = otp_u2_bits;
        end
    end

    // Image is pulled in on the first edge after release, not under reset
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            image_load_q <= 1'b1;
        else
            image_load_q <= 1'b0;
    end

    // Write channels accepted in either order
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            aw_held_q <= 1'b0;
            awaddr_q <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end
        else if (wr_fire)
            aw_held_q <= 1'b0;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            w_held_q <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end
        else if (wr_fire)
            w_held_q <= 1'b0;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= ULPT_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= reg_hit(awaddr_q) ? ULPT_RESP_OKAY : ULPT_RESP_DECERR;
        end
        else if (s_axi_bready)
            bvalid_q <= 1'b0;
    end

    assign s_axi_awready = ~aw_held_q & ~bvalid_q;
    assign s_axi_wready = ~w_held_q & ~bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // Reload beats a software write in the same cycle
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            u1_idle_wait_us_q <= ULPT_U1_RESET;
        else if (reload)
            u1_idle_wait_us_q <= image_u1;
        else if (wr_hit)
            u1_idle_wait_us_q <= byte_merge(u1_idle_wait_us_q,
                wdata_q[ULPT_U1_LSB +: 8], wstrb_q[3]);
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            hs_phy_delay_trim_q <= ULPT_TRIM_RESET;
        else if (reload)
            hs_phy_delay_trim_q <= ULPT_TRIM_RESET;
        else if (wr_hit && wstrb_q[1])
            hs_phy_delay_trim_q <= wdata_q[ULPT_TRIM_LSB +: 3];
    end

    // Protection keeps the U2 bits across link resets, not power-up load
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            u2_entry_initiation_allow_q <= ULPT_U2_INIT_RESET;
            u2_host_request_accept_q <= ULPT_U2_ACC_RESET;
        end
        else if (image_load_q || (link_reset && !reset_protect))
        begin
            u2_entry_initiation_allow_q <= image_u2[1];
            u2_host_request_accept_q <= image_u2[0];
        end
        else if (wr_hit && wstrb_q[1])
        begin
            u2_entry_initiation_allow_q <= wdata_q[ULPT_U2_INIT_BIT];
            u2_host_request_accept_q <= wdata_q[ULPT_U2_ACC_BIT];
        end
    end

    // Value from the downstream port, as programmed by host software
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            u2_inactivity_limit_q <= ULPT_U2_RESET;
        else if (link_reset)
            u2_inactivity_limit_q <= ULPT_U2_RESET;
        else if (lmp_u2_valid)
            u2_inactivity_limit_q <= lmp_u2_value;
    end

    always_comb
    begin
        cfg_word = '0;
        cfg_word[ULPT_U1_LSB +: 8] = u1_idle_wait_us_q;
        cfg_word[ULPT_U2_LSB +: 8] = u2_inactivity_limit_q;
        cfg_word[ULPT_TRIM_LSB +: 3] = hs_phy_delay_trim_q;
        cfg_word[ULPT_U2_INIT_BIT] = u2_entry_initiation_allow_q;
        cfg_word[ULPT_U2_ACC_BIT] = u2_host_request_accept_q;
    end

    // Read: one cycle from address to data
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rvalid_q <= 1'b0;
            rresp_q <= ULPT_RESP_OKAY;
            rdata_q <= '0;
        end
        else if (s_axi_arvalid && !rvalid_q)
        begin
            rvalid_q <= 1'b1;
            if (reg_hit(s_axi_araddr))
            begin
                rresp_q <= ULPT_RESP_OKAY;
                rdata_q <= cfg_word;
            end
            else
            begin
                rresp_q <= ULPT_RESP_DECERR;
                rdata_q <= '0;
            end
        end
        else if (s_axi_rready)
            rvalid_q <= 1'b0;
    end

    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // U2 permits: each bit drives its own path only
    assign u2_initiate_permit = u2_entry_initiation_allow_q &
                                host_u2_feature;
    assign u2_accept_permit = u2_host_request_accept_q;

    // U1 inactivity wait in whole microseconds
    logic u1_armed;
    logic [7:0] us_prescale_q;
    logic [7:0] u1_elapsed_q;
    logic u1_done_q;
    logic u1_request_q;

    assign u1_armed = host_u1_feature & link_idle & ~link_reset;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            us_prescale_q <= '0;
        else if (!u1_armed || us_prescale_q == US_PRESCALE_LAST)
            us_prescale_q <= '0;
        else
            us_prescale_q <= us_prescale_q + 8'h01;
    end

    // Fires once per idle stretch; activity re-arms it
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            u1_elapsed_q <= '0;
            u1_done_q <= 1'b0;
            u1_request_q <= 1'b0;
        end
        else if (!u1_armed)
        begin
            u1_elapsed_q <= '0;
            u1_done_q <= 1'b0;
            u1_request_q <= 1'b0;
        end
        else
        begin
            u1_request_q <= 1'b0;
            if (!u1_done_q && u1_elapsed_q >= u1_idle_wait_us_q)
            begin
                u1_done_q <= 1'b1;
                u1_request_q <= 1'b1;
            end
            else if (!u1_done_q && us_prescale_q == US_PRESCALE_LAST)
                u1_elapsed_q <= u1_elapsed_q + 8'h01;
        end
    end

    assign u1_entry_request = u1_request_q;

    // High-speed inter-packet timeout, 60 MHz factor only
    localparam logic [9:0] HS_BASE = 10'(HS_BASE_BITS);
    localparam logic [9:0] HS_STEP = 10'(ULPT_HS_BITS_PER_PHY_CLK);

    logic [9:0] hs_limit_q;
    logic [9:0] hs_count_q;
    logic hs_expired_q;
    ulpt_hs_state_t hs_state_q;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            hs_limit_q <= HS_BASE;
        else
            hs_limit_q <= HS_BASE + 10'(hs_phy_delay_trim_q) * HS_STEP;
    end

    assign hs_timeout_bits = hs_limit_q;

    // Limit sampled each bit; trim changes apply to the running wait
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            hs_state_q <= ULPT_HS_IDLE;
            hs_count_q <= '0;
            hs_expired_q <= 1'b0;
        end
        else
        begin
            hs_expired_q <= 1'b0;
            case (hs_state_q)
                ULPT_HS_IDLE:
                begin
                    if (hs_wait_start)
                    begin
                        hs_state_q <= ULPT_HS_WAIT;
                        hs_count_q <= '0;
                    end
                end
                ULPT_HS_WAIT:
                begin
                    if (hs_wait_stop || link_reset)
                        hs_state_q <= ULPT_HS_IDLE;
                    else if (hs_bit_tick)
                    begin
                        if (hs_count_q + 10'h001 >= hs_limit_q)
                        begin
                            hs_expired_q <= 1'b1;
                            hs_state_q <= ULPT_HS_IDLE;
                        end
                        else
                            hs_count_q <= hs_count_q + 10'h001;
                    end
                end
                default:
                    hs_state_q <= ULPT_HS_IDLE;
            endcase
        end
    end

    assign hs_wait_expired = hs_expired_q;

endmodule

//--- core/ulpt_pkg.sv
package ulpt_pkg;

    // Register map
    localparam logic [11:0] ULPT_CFG_OFFSET = 12'h084;

    // Field positions
    localparam int ULPT_U1_LSB = 24;
    localparam int ULPT_U2_LSB = 16;
    localparam int ULPT_TRIM_LSB = 13;
    localparam int ULPT_U2_INIT_BIT = 12;
    localparam int ULPT_U2_ACC_BIT = 11;

    // Values after reset, also the image when nothing is programmed
    localparam logic [7:0] ULPT_U1_RESET = 8'h00;
    localparam logic [7:0] ULPT_U2_RESET = 8'h00;
    localparam logic [2:0] ULPT_TRIM_RESET = 3'h0;
    localparam logic ULPT_U2_INIT_RESET = 1'b0;
    localparam logic ULPT_U2_ACC_RESET = 1'b0;

    // Timing
    localparam int ULPT_CLK_PERIOD_PS = 5000;
    localparam int ULPT_US_PS = 1000000;
    localparam int ULPT_CYCLES_PER_US = ULPT_US_PS / ULPT_CLK_PERIOD_PS;
    localparam int ULPT_HS_BITS_PER_PHY_CLK = 8;
    localparam int ULPT_HS_TIMEOUT_MIN = 736;
    localparam int ULPT_HS_TIMEOUT_MAX = 816;
    localparam int ULPT_HS_BASE_DEFAULT = 736;

    // AXI responses
    localparam logic [1:0] ULPT_RESP_OKAY = 2'h0;
    localparam logic [1:0] ULPT_RESP_DECERR = 2'h3;

    typedef enum logic
    {
        ULPT_HS_IDLE,
        ULPT_HS_WAIT
    } ulpt_hs_state_t;

endpackage

//--- tb/tb_top.sv
module tb_top
    import ulpt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, usb_bus_reset, lite_soft_reset, reset_protect;
    logic eeprom_present, otp_programmed, s_axi_awvalid, s_axi_awready;
    logic [7:0] eeprom_u1_wait, otp_u1_wait, lmp_u2_value;
    logic [1:0] eeprom_u2_bits, otp_u2_bits, s_axi_bresp, s_axi_rresp, rs;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic host_u1_feature, host_u2_feature, link_idle, lmp_u2_valid;
    logic u1_entry_request, u2_initiate_permit, u2_accept_permit;
    logic hs_bit_tick, hs_wait_start, hs_wait_stop, hs_wait_expired;
    logic [9:0] hs_timeout_bits;
    int miscompares = 0;
    int num_checks = 0;

    ulpt_link_power_cfg u_ulpt_link_power_cfg (.*);
    ulpt_hm u_ulpt_hm (.*);

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] g, e, input string m);
        num_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %0t %s %h %h", $time, m, g, e);
        end
    endtask

    // Either channel may be taken first
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        logic aw, w;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(negedge clk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            @(posedge clk);
            if (aw)
                s_axi_awvalid <= 1'b0;
            if (w)
                s_axi_wvalid <= 1'b0;
        end while ((s_axi_awvalid && !aw) || (s_axi_wvalid && !w));
        do @(negedge clk); while (!s_axi_bvalid);
        rs = s_axi_bresp;
        @(posedge clk);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rdr(input logic [11:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(negedge clk); while (!s_axi_arready);
        @(posedge clk);
        s_axi_arvalid <= 1'b0;
        do @(negedge clk); while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        @(posedge clk);
        s_axi_rready <= 1'b0;
    endtask

    task automatic rchk(input logic [31:0] e, input string m);
        rdr(ULPT_CFG_OFFSET);
        chk(rd, e, m);
    endtask

    task automatic pulse_rst(input logic lite, prot);
        @(posedge clk);
        reset_protect <= prot;
        {lite_soft_reset, usb_bus_reset} <= {lite, !lite};
        @(posedge clk);
        {lite_soft_reset, usb_bus_reset} <= 2'h0;
    endtask

    task automatic sc_fields;
        rchk(32'h0300_1800, "reset image");
        wr(ULPT_CFG_OFFSET, 32'hFFFF_FFFF, 4'hF);
        rchk(32'hFF00_F800, "ro field");
        chk(hs_timeout_bits, 10'h318, "trim max");
        wr(ULPT_CFG_OFFSET, 32'h0000_0000, 4'h2);
        rchk(32'hFF00_0000, "lane");
        chk(hs_timeout_bits, 10'h2E0, "trim zero");
        wr(12'h088, 32'hFFFF_FFFF, 4'hF);
        chk({30'h0, rs}, {30'h0, ULPT_RESP_DECERR}, "bad wr");
        rdr(12'h088);
        chk({30'h0, rs}, {30'h0, ULPT_RESP_DECERR}, "bad rd");
        rchk(32'hFF00_0000, "unchanged");
    endtask

    task automatic sc_permit;
        for (int i = 0; i < 8; i++)
        begin
            wr(ULPT_CFG_OFFSET, {19'h0, i[2:1], 11'h0}, 4'h2);
            u_ulpt_hm.set_link(1'b0, i[0], 1'b0);
            @(negedge clk);
            chk(u2_initiate_permit, i[2] & i[0], "init");
            chk(u2_accept_permit, i[1], "accept");
        end
    endtask

    task automatic sc_u1;
        int n = 0;
        wr(ULPT_CFG_OFFSET, 32'h0200_0000, 4'h8);
        u_ulpt_hm.set_link(1'b1, 1'b0, 1'b1);
        do
        begin
            @(negedge clk);
            n++;
        end while (!u1_entry_request && n < 600);
        chk(n >= 399 && n <= 404, 1'b1, "u1 wait");
        n = 0;
        repeat (500)
        begin
            @(negedge clk);
            n += u1_entry_request;
        end
        chk(n, 0, "u1 once");
        u_ulpt_hm.set_link(1'b0, 1'b0, 1'b0);
    endtask

    task automatic hs_one(input logic [31:0] d, input int g,
                          input logic [9:0] e);
        int e0;
        wr(ULPT_CFG_OFFSET, d, 4'h2);
        // Limit follows the trim one edge after the write lands
        @(negedge clk);
        chk(hs_timeout_bits, e, "timeout");
        e0 = u_ulpt_hm.exp_cnt;
        u_ulpt_hm.hs_start(g);
        while (u_ulpt_hm.exp_cnt == e0)
            @(negedge clk);
        u_ulpt_hm.hs_halt;
        chk(u_ulpt_hm.last_cnt, e, "ticks");
    endtask

    task automatic sc_hs;
        int e0;
        hs_one(32'h0000_6000, 1, 10'h2F8);
        hs_one(32'h0000_0000, 2, 10'h2E0);
        e0 = u_ulpt_hm.exp_cnt;
        u_ulpt_hm.hs_start(1);
        repeat (100) @(posedge clk);
        u_ulpt_hm.hs_stop;
        repeat (900) @(posedge clk);
        u_ulpt_hm.hs_halt;
        chk(u_ulpt_hm.exp_cnt, e0, "abort");
    endtask

    task automatic sc_resets;
        wr(ULPT_CFG_OFFSET, 32'hFF00_F000, 4'hF);
        u_ulpt_hm.send_lmp(8'hA5);
        rchk(32'hFFA5_F000, "lmp");
        pulse_rst(1'b0, 1'b1);
        rchk(32'h0300_1000, "kept");
        eeprom_present <= 1'b0;
        pulse_rst(1'b1, 1'b0);
        rchk(32'h0500_0800, "otp image");
        otp_programmed <= 1'b0;
        pulse_rst(1'b0, 1'b0);
        rchk(32'h0000_0000, "no image");
    endtask

    task automatic complete_run;
        if (miscompares == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        {nrst, usb_bus_reset, lite_soft_reset, reset_protect} = 4'h0;
        {eeprom_present, otp_programmed} = 2'h3;
        {eeprom_u1_wait, otp_u1_wait} = {8'h03, 8'h05};
        {eeprom_u2_bits, otp_u2_bits} = {2'h3, 2'h1};
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        sc_fields;
        sc_permit;
        sc_u1;
        sc_hs;
        sc_resets;
        complete_run;
    end

    // Whole run needs about 4300 cycles
    initial
    begin
        #100000;
        miscompares++;
        complete_run;
    end
endmodule

//--- tb/ulpt_hm.sv
module ulpt_hm
    import ulpt_pkg::*;
(
    input wire logic clk,
    input wire logic hs_wait_expired,
    output logic host_u1_feature,
    output logic host_u2_feature,
    output logic link_idle,
    output logic lmp_u2_valid,
    output logic [7:0] lmp_u2_value,
    output logic hs_bit_tick,
    output logic hs_wait_start,
    output logic hs_wait_stop
);
    timeunit 1ns;
    timeprecision 1ps;
    int gap = 0;
    int ph = 0;
    int tick_cnt = 0;
    int exp_cnt = 0;
    int last_cnt = 0;

    initial
    begin
        {host_u1_feature, host_u2_feature, link_idle} = 3'h0;
        {lmp_u2_valid, hs_bit_tick, hs_wait_start, hs_wait_stop} = 4'h0;
        lmp_u2_value = 8'h5A;
    end

    // Ticks from hs_start until hs_halt, even after a stop or expiry; count seen before expiry
    always @(posedge clk)
    begin
        ph <= (ph + 1 >= gap) ? 0 : ph + 1;
        hs_bit_tick <= (gap != 0) && (ph == 0);
        if (hs_wait_start)
            tick_cnt <= 0;
        else if (hs_bit_tick)
            tick_cnt <= tick_cnt + 1;
        if (hs_wait_expired)
        begin
            exp_cnt <= exp_cnt + 1;
            last_cnt <= tick_cnt;
        end
    end

    task automatic set_link(input logic f1, f2, idle);
        @(posedge clk);
        {host_u1_feature, host_u2_feature, link_idle} <= {f1, f2, idle};
    endtask

    // Value line scrambled once the packet is over
    task automatic send_lmp(input logic [7:0] v);
        @(posedge clk);
        lmp_u2_valid <= 1'b1;
        lmp_u2_value <= v;
        @(posedge clk);
        lmp_u2_valid <= 1'b0;
        lmp_u2_value <= ~v;
    endtask

    task automatic hs_start(input int g);
        @(posedge clk);
        hs_wait_start <= 1'b1;
        gap <= g;
        @(posedge clk);
        hs_wait_start <= 1'b0;
    endtask

    task automatic hs_stop;
        @(posedge clk);
        hs_wait_stop <= 1'b1;
        @(posedge clk);
        hs_wait_stop <= 1'b0;
    endtask

    task automatic hs_halt;
        @(posedge clk);
        gap <= 0;
    endtask
endmodule

//--- tb/ulpt_link_power_monitor.sv
module ulpt_link_power_monitor
    import ulpt_pkg::*;
#(
    parameter int HS_BASE_BITS = ULPT_HS_BASE_DEFAULT
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic host_u1_feature,
    input wire logic host_u2_feature,
    input wire logic link_idle,
    input wire logic u1_entry_request,
    input wire logic u2_initiate_permit,
    input wire logic u2_accept_permit,
    input wire logic hs_bit_tick,
    input wire logic [9:0] hs_timeout_bits,
    input wire logic hs_wait_expired
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    a_u2_init_gate: assert property (
        u2_initiate_permit |-> host_u2_feature)
        else $error("u2 initiate without host enable");
    a_u2_acc_indep: assert property (
        $changed(host_u2_feature) && !s_axi_bvalid
        |-> $stable(u2_accept_permit))
        else $error("u2 accept follows host enable");
    a_u1_armed_only: assert property (
        u1_entry_request |-> $past(host_u1_feature && link_idle))
        else $error("u1 request while not armed");
    a_u1_one_pulse: assert property (
        u1_entry_request |=> !u1_entry_request)
        else $error("u1 request longer than one cycle");
    a_hs_trim_range: assert property (
        hs_timeout_bits >= HS_BASE_BITS
        && hs_timeout_bits <= HS_BASE_BITS + 56
        && (hs_timeout_bits - HS_BASE_BITS) % 8 == 0)
        else $error("hs timeout off the trim grid");
    a_hs_tick_cause: assert property (
        hs_wait_expired |-> $past(hs_bit_tick))
        else $error("hs expiry without a bit tick");
    a_hs_one_pulse: assert property (
        hs_wait_expired |=> !hs_wait_expired)
        else $error("hs expiry longer than one cycle");
    a_rd_answer_next: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rd_data_held: assert property (
        s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");

    c_u1_request: cover property (u1_entry_request);
    c_hs_expired: cover property (hs_wait_expired);
    c_decode_err: cover property (
        s_axi_bvalid && s_axi_bresp == ULPT_RESP_DECERR);
endmodule

bind ulpt_link_power_cfg ulpt_link_power_monitor
    #(.HS_BASE_BITS(HS_BASE_BITS)) u_ulpt_link_power_monitor (.*);
